// File: common/gsm_pkg.sv
// shared constants for the user glyph ram and symbol register block
package gsm_pkg;
  localparam int unsigned CLK_HZ         = 25000000;
  localparam int unsigned RESET_SETTLE_US = 10;
  localparam int unsigned SETTLE_CYC     = (RESET_SETTLE_US * (CLK_HZ / 1000000) < 1) ? 1 :
                                           RESET_SETTLE_US * (CLK_HZ / 1000000);
  localparam int unsigned FRAME_HZ       = 100;
  localparam int unsigned DIGITS_12      = 12;
  localparam int unsigned DIGITS_16      = 16;
  localparam int unsigned DUTY_INV       = 30;
  localparam int unsigned GLYPHS         = 4;
  localparam int unsigned GLYPH_ROWS     = 7;
  localparam int unsigned GLYPH_COLS     = 5;
  localparam int unsigned GLYPH_BITS     = GLYPHS * GLYPH_ROWS * GLYPH_COLS;
  localparam int unsigned SYM_BITS       = 64;
  localparam int unsigned SYM_BYTES      = 16;
  localparam logic [6:0]  SYM_BASE       = 7'h70;
  localparam logic [3:0]  SYM_LAST_12    = 4'hc;
  localparam logic [3:0]  SYM_LAST_16    = 4'hf;
  localparam logic [2:0]  ROW_UNUSED     = 3'h7;
  localparam int unsigned SYM_LSB        = 1;
  localparam int unsigned ROW_W          = 5;
  localparam int unsigned WORDS          = 32;
endpackage

// File: verilog/gsm_glyph_mem.sv
// user glyph storage: 32 rows of five dots, registered read port
`timescale 1ns/10ps
module gsm_glyph_mem
  import gsm_pkg::*;
#(
  parameter int unsigned WIDTH = ROW_W,
  parameter int unsigned DEPTH = WORDS
) (
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_we,
  input  wire logic [$clog2(DEPTH)-1:0] i_waddr,
  input  wire logic [WIDTH-1:0]         i_wdata,
  input  wire logic [$clog2(DEPTH)-1:0] i_raddr,
  output logic      [WIDTH-1:0]         o_rdata
);
  // contents are undefined after reset; the host clears them as needed
  logic [WIDTH-1:0] mem [DEPTH];
  always_ff @(posedge i_clk_sys) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule

// File: verilog/gsm_glyph_symbol_map.sv
// user glyph ram, symbol register, reset settling and frame/pump clock enables
`timescale 1ns/10ps
module gsm_glyph_symbol_map
  import gsm_pkg::*;
#(
  parameter int unsigned SETTLE  = SETTLE_CYC,
  parameter int unsigned OSC_DIV = CLK_HZ / (DIGITS_16 * DUTY_INV * FRAME_HZ)
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rstn,
  input  wire logic        i_wr,
  input  wire logic [6:0]  i_addr,
  input  wire logic [7:0]  i_data,
  input  wire logic        i_glyph_en,
  input  wire logic        i_digits16,
  input  wire logic        i_rd,
  input  wire logic [1:0]  i_rd_code,
  input  wire logic [2:0]  i_rd_row,
  output logic             o_ready,
  output logic [4:0]       o_row_dots,
  output logic             o_row_valid,
  output logic [63:0]      o_symbols,
  output logic             o_osc_en,
  output logic             o_frame_en,
  output logic             o_pump_en
);
  typedef enum logic [0:0] {GSM_SETTLING, GSM_READY} gsm_state_t;

  typedef struct packed {
    gsm_state_t  st;
    logic [31:0] settle;
    logic [31:0] osc;
    logic [7:0]  digit;
    logic [4:0]  line;
    logic        pump_half;
    logic [63:0] sym;
    logic        rd_pend;
    logic        osc_p;
    logic        frame_p;
    logic        pump_p;
  } gsm_regs_t;

  gsm_regs_t r_q, r_d;
  logic      glyph_we;
  logic [4:0] mem_rdata;
  logic [7:0] digits;
  logic [3:0] sym_idx;
  logic [3:0] sym_last;

  assign digits   = i_digits16 ? 8'(DIGITS_16) : 8'(DIGITS_12);
  assign sym_last = i_digits16 ? SYM_LAST_16 : SYM_LAST_12;
  assign sym_idx  = i_addr[3:0];
  // rows x7 are stored too, but display never reads them
  assign glyph_we = i_wr && (r_q.st == GSM_READY) && (i_addr[6:5] == 2'h0);

  gsm_glyph_mem #(
    .WIDTH (ROW_W),
    .DEPTH (WORDS)
  ) u_mem (
    .i_clk_sys (i_clk_sys),
    .i_we      (glyph_we),
    .i_waddr   (i_addr[4:0]),
    .i_wdata   (i_data[4:0]),
    .i_raddr   ({i_rd_code, i_rd_row}),
    .o_rdata   (mem_rdata)
  );

  always_comb begin
    r_d         = r_q;
    r_d.osc_p   = 1'b0;
    r_d.frame_p = 1'b0;
    r_d.pump_p  = 1'b0;
    r_d.rd_pend = 1'b0;
    unique case (r_q.st)
      GSM_SETTLING: begin
        if (r_q.settle >= 32'(SETTLE - 1)) begin
          r_d.st = GSM_READY;
        end else begin
          r_d.settle = r_q.settle + 32'h1;
        end
      end
      GSM_READY: begin
        // row 7 is a gap slot; reading it yields blank dots
        r_d.rd_pend = i_rd && i_glyph_en && (i_rd_row != ROW_UNUSED);
        if (i_wr && (i_addr[6:4] == SYM_BASE[6:4]) && (sym_idx <= sym_last)) begin
          r_d.sym[sym_idx*4 +: 4] = i_data[SYM_LSB +: 4];
        end
        // oscillator enable; frame every digits*duty ticks, pump every 2*digits ticks
        if (r_q.osc >= 32'(OSC_DIV - 1)) begin
          r_d.osc   = 32'h0;
          r_d.osc_p = 1'b1;
          if (r_q.digit >= digits - 8'h1) begin
            r_d.digit     = 8'h0;
            r_d.pump_half = ~r_q.pump_half;
            r_d.pump_p    = r_q.pump_half;
            if (r_q.line >= 5'(DUTY_INV - 1)) begin
              r_d.line    = 5'h0;
              r_d.frame_p = 1'b1;
            end else begin
              r_d.line = r_q.line + 5'h1;
            end
          end else begin
            r_d.digit = r_q.digit + 8'h1;
          end
        end else begin
          r_d.osc = r_q.osc + 32'h1;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  always_comb begin
    o_symbols = r_q.sym;
    // symbols beyond the twelve-digit range stay dark in 12-digit mode
    if (!i_digits16) begin
      o_symbols[SYM_BITS-1:(SYM_LAST_12+1)*4] = '0;
    end
  end

  assign o_ready     = (r_q.st == GSM_READY);
  assign o_row_dots  = r_q.rd_pend ? mem_rdata : 5'h0;
  assign o_row_valid = r_q.rd_pend;
  assign o_osc_en    = r_q.osc_p;
  assign o_frame_en  = r_q.frame_p;
  assign o_pump_en   = r_q.pump_p;
endmodule

// File: sim/gsm_map_chk.sv
// port assertions for the glyph and symbol map
`timescale 1ns/10ps
module gsm_map_chk #(parameter int unsigned SETTLE = 4) (
  input wire logic i_clk_sys, i_rstn, i_wr, i_rd, i_glyph_en, i_digits16, o_ready, o_row_valid, o_frame_en, o_pump_en,
  input wire logic [6:0] i_addr, input wire logic [7:0] i_data, input wire logic [2:0] i_rd_row,
  input wire logic [63:0] o_symbols);
  logic [15:0] cnt_q;
  wire logic fetch = i_rd && o_ready && i_glyph_en && i_rd_row != 3'h7;
  always_ff @(posedge i_clk_sys) cnt_q <= i_rstn ? cnt_q + 16'h1 : 16'h0;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  rdy_rst_a: assert property ($rose(i_rstn) |-> !o_ready) else $error("ready at release");
  rdy_late_a: assert property ($rose(o_ready) |-> cnt_q >= SETTLE - 1) else $error("ready early");
  rdy_bound_a: assert property ($rose(i_rstn) |-> ##[1:300] o_ready) else $error("ready late");
  row_ans_a: assert property (fetch |=> o_row_valid) else $error("row missing");
  row_none_a: assert property (!fetch |=> !o_row_valid) else $error("row extra");
  sym_map_a: assert property (i_wr && o_ready && i_addr == 7'h70 |=> o_symbols[3:0] == $past(i_data[4:1]))
    else $error("symbol bits");
  sym_clamp_a: assert property (!i_digits16 ##1 !i_digits16 |-> o_symbols[63:52] == 12'h0)
    else $error("symbol clamp");
  pump_gap_a: assert property (o_pump_en |=> !o_pump_en [*8]) else $error("pump rate");
  cover property ($rose(o_ready));
  cover property (fetch ##1 o_row_valid);
  cover property (o_frame_en);
endmodule
bind gsm_glyph_symbol_map gsm_map_chk #(.SETTLE(SETTLE)) chk_i (.*);

// File: sim/gsm_host_model.sv
// host side: presents each byte write one clock after the request
`timescale 1ns/10ps
module gsm_host_model (input wire logic i_clk_sys, i_go, input wire logic [6:0] i_a, input wire logic [7:0] i_d,
  output logic o_wr = 1'b0, output logic [6:0] o_addr = 7'h0, output logic [7:0] o_data = 8'h0);
  always_ff @(posedge i_clk_sys) begin
    o_wr <= i_go;
    o_addr <= i_a;
    o_data <= i_go ? i_d : ~o_data; // idle bus inverts the data byte on every clock, so the last byte returns every second idle clock
  end
endmodule

// File: sim/test_gsm_glyph_symbol_map.sv
// self-checking bench: ready timing, symbol bytes, glyph rows
`timescale 1ns/10ps
module test_gsm_glyph_symbol_map;
  import gsm_pkg::*;
  logic clk = 0, rstn = 0, go = 0, wr, rd = 0, gen = 1, d16 = 1, rdy, rv, fe, pe, oe;
  int t0 = 0;
  logic [6:0] a = 0, addr;
  logic [7:0] d = 0, data;
  logic [1:0] rc = 0;
  logic [2:0] rr = 0;
  logic [4:0] dots, g[32], q[$];
  logic [63:0] sym, xs = 0;
  logic [31:0] lf = 32'h7f59;
  int miscompares = 0, comparisons = 0, cyc = 0;
  initial forever #20 clk = ~clk;
  gsm_host_model host (.i_clk_sys(clk), .i_go(go), .i_a(a), .i_d(d), .o_wr(wr), .o_addr(addr), .o_data(data));
  gsm_glyph_symbol_map #(.SETTLE(4), .OSC_DIV(2)) uut (.i_clk_sys(clk), .i_rstn(rstn), .i_wr(wr), .i_addr(addr),
    .i_data(data), .i_glyph_en(gen), .i_digits16(d16), .i_rd(rd), .i_rd_code(rc), .i_rd_row(rr), .o_ready(rdy),
    .o_row_dots(dots), .o_row_valid(rv), .o_symbols(sym), .o_osc_en(oe), .o_frame_en(fe), .o_pump_en(pe));
  function logic [31:0] nx(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task chk(logic [63:0] s, logic [63:0] e, string n);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task stop_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(negedge clk) if (rv === 1'b1) begin
    if (q.size() == 0) chk(1, 0, "extra row");
    else chk(dots, q.pop_front(), "row");
  end
  always @(posedge clk) if (++cyc == 4000) begin
    miscompares++;
    stop_test;
  end
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1;
    repeat (3) @(posedge clk);
    @(negedge clk) chk(rdy, 0, "early ready");
    repeat (4) @(posedge clk);
    @(negedge clk) chk(rdy, 1, "ready");
    $display("ready test done");
    for (int m = 1; m >= 0; m--) begin
      @(posedge clk) d16 <= m[0];
      for (int k = 0; k < 16; k++) begin
        lf = nx(lf);
        go <= 1; a <= 7'h70 + k[6:0]; d <= lf[7:0];
        if (m == 1 || k < 13) xs[4*k+:4] = lf[4:1]; // 12-digit mode refuses 7d-7f
        @(posedge clk);
      end
      go <= 0;
      repeat (2) @(posedge clk);
      @(negedge clk) chk(sym, m ? xs : {12'h0, xs[51:0]}, "symbols");
    end
    $display("symbol test done");
    @(posedge clk);
    for (int i = 0; i < 32; i++) begin
      lf = nx(lf);
      go <= 1; a <= i[6:0]; d <= lf[7:0]; g[i] = lf[4:0];
      @(posedge clk);
    end
    go <= 0;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 32; i++) begin
      rd <= 1; rc <= i[4:3]; rr <= i[2:0];
      if (i[2:0] != 3'h7) q.push_back(g[i]);
      @(posedge clk);
    end
    gen <= 0; rr <= 0;
    @(posedge clk) rd <= 0;
    repeat (4) @(posedge clk);
    chk(q.size(), 0, "rows pending");
    $display("glyph test done");
    // periods are measured between pulse starts; enable divider is 2 in this bench
    do @(negedge clk); while (oe !== 1'b1);
    t0 = cyc;
    do @(negedge clk); while (oe !== 1'b1);
    chk(cyc - t0, 2, "osc period");
    do @(negedge clk); while (pe !== 1'b1);
    t0 = cyc;
    do @(negedge clk); while (pe !== 1'b1);
    chk(cyc - t0, 2 * DIGITS_12 * 2, "pump period");
    do @(negedge clk); while (fe !== 1'b1);
    t0 = cyc;
    do @(negedge clk); while (fe !== 1'b1);
    chk(cyc - t0, DIGITS_12 * DUTY_INV * 2, "frame period");
    $display("clock enable test done");
    stop_test;
  end
endmodule
